// ===== rtl/conv_cfg_pkg.sv
// constants shared by the media converter configuration and link control logic
package conv_cfg_pkg;

	// three-level strap codes
	typedef enum logic [1:0] {
		LVL_LOW  = 2'h0,
		LVL_MID  = 2'h1,
		LVL_HIGH = 2'h2
	} level_t;

	// rates of the main clock and of the reference clock, in kHz
	localparam int unsigned MCLK_KHZ = 125000;
	localparam int unsigned REF_KHZ = 25000;

	// strap sampling delay after power-down release, inside the 3 to 8 ms window
	localparam int unsigned STRAP_DELAY_MS = 5;
	localparam int unsigned STRAP_DELAY_TICKS = STRAP_DELAY_MS * REF_KHZ;
	localparam int STRAP_CNT_W = 17;

	// transmitter blanking timing
	localparam int unsigned WARN_PERIOD_MS = 3800;
	localparam int unsigned WARN_OFF_MS = 425;
	localparam int unsigned WARN_FAST_PERIOD_MS = 934;
	localparam int unsigned WARN_FAST_OFF_MS = 104;
	localparam int unsigned WARN_PERIOD_TICKS = WARN_PERIOD_MS * REF_KHZ;
	localparam int unsigned WARN_OFF_TICKS = WARN_OFF_MS * REF_KHZ;
	localparam int unsigned WARN_FAST_PERIOD_TICKS = WARN_FAST_PERIOD_MS * REF_KHZ;
	localparam int unsigned WARN_FAST_OFF_TICKS = WARN_FAST_OFF_MS * REF_KHZ;
	localparam int WARN_CNT_W = 27;

	// management frame layout
	localparam logic [5:0] MGMT_PREAMBLE_LEN = 6'h20;
	localparam logic [1:0] MGMT_OP_READ = 2'h2;
	localparam logic [1:0] MGMT_OP_WRITE = 2'h1;
	localparam logic [4:0] MGMT_LAST_ADDR_BIT = 5'h04;
	localparam logic [4:0] MGMT_LAST_DATA_BIT = 5'h0F;
	localparam logic [4:0] MGMT_REG_TEST = 5'h1C;
	localparam int MGMT_TEST_FAST_BIT = 0;

	// reset values
	localparam logic TEST_FAST_RST = 1'b0;
	localparam logic [4:0] PHY_ADDR_RST = 5'h00;

	// synchroniser width: refclk, mdc, mdio, pd, two disables, four level bits, six address bits
	localparam int PIN_W = 16;

endpackage

// ===== rtl/pin_sync.sv
// three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module pin_sync #(
	parameter int W = 1
) (
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic [W-1:0] i_pin,
	output logic [W-1:0] o_level
);

	logic [W-1:0] s1_q, s2_q, s3_q, lvl_q;
	logic [W-1:0] lvl_d;

	always_comb begin
		lvl_d = lvl_q;
		for (int i = 0; i < W; i++) begin
			if (s2_q[i] == s3_q[i]) begin
				lvl_d[i] = s3_q[i];
			end
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			lvl_q <= '0;
		end else begin
			s1_q <= i_pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
			lvl_q <= lvl_d;
		end
	end

	assign o_level = lvl_q;

endmodule

// ===== rtl/link_blank_timer.sv
// periodic transmitter blanking timer for one network interface
`timescale 1ns/1ps
module link_blank_timer
	import conv_cfg_pkg::*;
#(
	parameter logic [WARN_CNT_W-1:0] PERIOD = WARN_CNT_W'(WARN_PERIOD_TICKS),
	parameter logic [WARN_CNT_W-1:0] OFF = WARN_CNT_W'(WARN_OFF_TICKS),
	parameter logic [WARN_CNT_W-1:0] FAST_PERIOD = WARN_CNT_W'(WARN_FAST_PERIOD_TICKS),
	parameter logic [WARN_CNT_W-1:0] FAST_OFF = WARN_CNT_W'(WARN_FAST_OFF_TICKS)
) (
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic i_tick,
	input wire logic i_run,
	input wire logic i_fast,
	output logic o_blank
);

	logic [WARN_CNT_W-1:0] cnt_q, cnt_d;
	logic blank_q, blank_d;
	logic [WARN_CNT_W-1:0] per, off;

	always_comb begin
		per = i_fast ? FAST_PERIOD : PERIOD;
		off = i_fast ? FAST_OFF : OFF;
		cnt_d = cnt_q;
		if (!i_run) begin
			cnt_d = '0;
		end else if (i_tick) begin
			// a mode switch mid-period simply wraps at the new length
			cnt_d = (cnt_q >= per - 1'b1) ? '0 : cnt_q + 1'b1;
		end
		// blanking opens the period so the partner sees the loss at once
		blank_d = i_run && (cnt_d < off);
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			cnt_q <= '0;
			blank_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			blank_q <= blank_d;
		end
	end

	assign o_blank = blank_q;

endmodule

// ===== rtl/converter_config_and_link_control.sv
// strap sampling, management access and transmitter control of the media converter
`timescale 1ns/1ps
module converter_config_and_link_control
	import conv_cfg_pkg::*;
#(
	parameter logic [STRAP_CNT_W-1:0] STRAP_TICKS = STRAP_CNT_W'(STRAP_DELAY_TICKS),
	parameter logic [WARN_CNT_W-1:0] PERIOD_TICKS = WARN_CNT_W'(WARN_PERIOD_TICKS),
	parameter logic [WARN_CNT_W-1:0] OFF_TICKS = WARN_CNT_W'(WARN_OFF_TICKS),
	parameter logic [WARN_CNT_W-1:0] FAST_PERIOD_TICKS = WARN_CNT_W'(WARN_FAST_PERIOD_TICKS),
	parameter logic [WARN_CNT_W-1:0] FAST_OFF_TICKS = WARN_CNT_W'(WARN_FAST_OFF_TICKS)
) (
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic i_reference_clock_in,
	input wire logic i_power_down_n,
	input wire logic i_copper_tx_disable_n,
	input wire logic i_fiber_tx_disable_n,
	input wire logic i_speed_strap_hi,
	input wire logic i_speed_strap_lo,
	input wire logic i_duplex_strap_hi,
	input wire logic i_duplex_strap_lo,
	input wire logic [1:0] i_phy_addr_low_strap,
	input wire logic [1:0] i_phy_addr_mid_strap,
	input wire logic [1:0] i_phy_addr_high_warn_strap,
	input wire logic i_copper_link_up,
	input wire logic i_fiber_link_up,
	input wire logic i_mdc,
	input wire logic i_mdio,
	output logic o_mdio,
	output logic o_mdio_oe,
	output logic [4:0] o_phy_addr,
	output logic [1:0] o_speed_code,
	output logic [1:0] o_duplex_code,
	output logic o_rate_100_en,
	output logic o_rate_10_en,
	output logic o_autoneg_en,
	output logic o_duplex_en,
	output logic o_transparent,
	output logic o_warn_en,
	output logic o_test_fast,
	output logic o_config_valid,
	output logic o_power_down,
	output logic o_copper_tx_en,
	output logic o_fiber_tx_en
);

	typedef enum logic [2:0] {
		MG_IDLE = 3'h0,
		MG_START = 3'h1,
		MG_OP = 3'h3,
		MG_PHY = 3'h2,
		MG_REG = 3'h6,
		MG_TA = 3'h7,
		MG_DATA = 3'h5
	} mgmt_state_t;

	function automatic level_t resolve_level(input logic hi, input logic lo);
		if (hi) begin
			return LVL_HIGH;
		end else if (lo) begin
			return LVL_LOW;
		end
		return LVL_MID;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisation and edge detection

	logic [PIN_W-1:0] pins, pins_s;
	logic ref_s, mdc_s, mdio_s, pd_n_s, cu_dis_n_s, fo_dis_n_s;
	logic spd_hi_s, spd_lo_s, dpx_hi_s, dpx_lo_s;
	logic [5:0] addr_s;
	logic ref_prev_q, mdc_prev_q;
	logic ref_tick, mdc_rise;

	assign pins = {i_reference_clock_in, i_mdc, i_mdio, i_power_down_n,
		i_copper_tx_disable_n, i_fiber_tx_disable_n,
		i_speed_strap_hi, i_speed_strap_lo, i_duplex_strap_hi, i_duplex_strap_lo,
		i_phy_addr_high_warn_strap, i_phy_addr_mid_strap, i_phy_addr_low_strap};

	pin_sync #(.W(PIN_W)) u_sync (
		.i_mclk(i_mclk),
		.i_rst_n(i_rst_n),
		.i_pin(pins),
		.o_level(pins_s)
	);

	assign {ref_s, mdc_s, mdio_s, pd_n_s, cu_dis_n_s, fo_dis_n_s,
		spd_hi_s, spd_lo_s, dpx_hi_s, dpx_lo_s, addr_s} = pins_s;

	// the reference clock becomes a one-cycle enable on its rising edge
	assign ref_tick = ref_s && !ref_prev_q;
	// mdc up to 12.5 MHz still leaves five main-clock cycles per phase
	assign mdc_rise = mdc_s && !mdc_prev_q;

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			ref_prev_q <= 1'b0;
			mdc_prev_q <= 1'b0;
		end else begin
			ref_prev_q <= ref_s;
			mdc_prev_q <= mdc_s;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// power-down and delayed strap sampling

	logic pend_q, pend_d;
	logic [STRAP_CNT_W-1:0] dly_q, dly_d;
	logic sample;
	logic valid_q, valid_d;
	level_t spd_q, spd_d, dpx_q, dpx_d;
	logic [4:0] addr_q, addr_d;
	logic warn_strap_q, warn_strap_d;
	logic pd_active;

	assign pd_active = !pd_n_s;

	always_comb begin
		pend_d = pend_q;
		dly_d = dly_q;
		sample = 1'b0;
		if (pd_active) begin
			pend_d = 1'b1;
			dly_d = '0;
		end else if (pend_q && ref_tick) begin
			if (dly_q >= STRAP_TICKS - 1'b1) begin
				sample = 1'b1;
				pend_d = 1'b0;
				dly_d = '0;
			end else begin
				dly_d = dly_q + 1'b1;
			end
		end
		valid_d = valid_q;
		spd_d = spd_q;
		dpx_d = dpx_q;
		addr_d = addr_q;
		warn_strap_d = warn_strap_q;
		if (sample) begin
			valid_d = 1'b1;
			spd_d = resolve_level(spd_hi_s, spd_lo_s);
			dpx_d = resolve_level(dpx_hi_s, dpx_lo_s);
			addr_d[1:0] = addr_s[1:0];
			addr_d[3:2] = addr_s[3:2];
			addr_d[4] = addr_s[4];
			warn_strap_d = addr_s[5];
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			pend_q <= 1'b1;
			dly_q <= '0;
			valid_q <= 1'b0;
			spd_q <= LVL_MID;
			dpx_q <= LVL_MID;
			addr_q <= PHY_ADDR_RST;
			warn_strap_q <= 1'b0;
		end else begin
			pend_q <= pend_d;
			dly_q <= dly_d;
			valid_q <= valid_d;
			spd_q <= spd_d;
			dpx_q <= dpx_d;
			addr_q <= addr_d;
			warn_strap_q <= warn_strap_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// management frame engine

	mgmt_state_t st_q, st_d;
	logic [5:0] ones_q, ones_d;
	logic [4:0] cnt_q, cnt_d;
	logic [15:0] sh_q, sh_d;
	logic [1:0] op_q, op_d;
	logic match_q, match_d;
	logic [4:0] reg_q, reg_d;
	logic oe_q, oe_d, out_q, out_d;
	logic fast_q, fast_d;
	logic [15:0] rd_data;
	logic rd_go;

	always_comb begin
		rd_data = '0;
		if (reg_q == MGMT_REG_TEST) begin
			rd_data[MGMT_TEST_FAST_BIT] = fast_q;
		end
		rd_go = match_q && (op_q == MGMT_OP_READ);
		st_d = st_q;
		ones_d = ones_q;
		cnt_d = cnt_q;
		sh_d = sh_q;
		op_d = op_q;
		match_d = match_q;
		reg_d = reg_q;
		oe_d = oe_q;
		out_d = out_q;
		fast_d = fast_q;
		if (pd_active) begin
			st_d = MG_IDLE;
			ones_d = '0;
			oe_d = 1'b0;
		end else if (mdc_rise) begin
			cnt_d = cnt_q + 1'b1;
			sh_d = {sh_q[14:0], mdio_s};
			case (st_q)
				MG_IDLE: begin
					cnt_d = '0;
					if (mdio_s) begin
						ones_d = (ones_q == MGMT_PREAMBLE_LEN) ? ones_q : ones_q + 1'b1;
					end else begin
						st_d = (ones_q == MGMT_PREAMBLE_LEN) ? MG_START : MG_IDLE;
						ones_d = '0;
					end
				end
				MG_START: begin
					cnt_d = '0;
					st_d = mdio_s ? MG_OP : MG_IDLE;
				end
				MG_OP: begin
					if (cnt_q[0]) begin
						op_d = {sh_q[0], mdio_s};
						cnt_d = '0;
						st_d = ({sh_q[0], mdio_s} == MGMT_OP_READ || {sh_q[0], mdio_s} == MGMT_OP_WRITE)
							? MG_PHY : MG_IDLE;
					end
				end
				MG_PHY: begin
					if (cnt_q == MGMT_LAST_ADDR_BIT) begin
						match_d = ({sh_q[3:0], mdio_s} == addr_q) && valid_q;
						cnt_d = '0;
						st_d = MG_REG;
					end
				end
				MG_REG: begin
					if (cnt_q == MGMT_LAST_ADDR_BIT) begin
						reg_d = {sh_q[3:0], mdio_s};
						cnt_d = '0;
						st_d = MG_TA;
					end
				end
				MG_TA: begin
					// the station lets go in the first turnaround bit, the device drives zero in the second
					if (cnt_q == '0) begin
						oe_d = rd_go;
						out_d = 1'b0;
					end else begin
						cnt_d = '0;
						st_d = MG_DATA;
						out_d = rd_data[15];
						sh_d = {rd_data[14:0], 1'b0};
					end
				end
				MG_DATA: begin
					if (rd_go) begin
						out_d = sh_q[15];
						sh_d = {sh_q[14:0], 1'b0};
					end
					if (cnt_q == MGMT_LAST_DATA_BIT) begin
						st_d = MG_IDLE;
						oe_d = 1'b0;
						out_d = 1'b0;
						if (match_q && op_q == MGMT_OP_WRITE && reg_q == MGMT_REG_TEST) begin
							fast_d = mdio_s;
						end
					end
				end
				default: begin
					st_d = MG_IDLE;
				end
			endcase
		end
		// register bits are put back to their defaults whenever the straps are read
		if (sample) begin
			fast_d = TEST_FAST_RST;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			st_q <= MG_IDLE;
			ones_q <= '0;
			cnt_q <= '0;
			sh_q <= '0;
			op_q <= '0;
			match_q <= 1'b0;
			reg_q <= '0;
			oe_q <= 1'b0;
			out_q <= 1'b0;
			fast_q <= TEST_FAST_RST;
		end else begin
			st_q <= st_d;
			ones_q <= ones_d;
			cnt_q <= cnt_d;
			sh_q <= sh_d;
			op_q <= op_d;
			match_q <= match_d;
			reg_q <= reg_d;
			oe_q <= oe_d;
			out_q <= out_d;
			fast_q <= fast_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// operating mode and transmitter control

	logic r100, r10, single_rate, warn_en;
	logic cu_run, fo_run, cu_blank, fo_blank, both_down;
	logic cu_en_q, cu_en_d, fo_en_q, fo_en_d;

	always_comb begin
		r100 = (spd_q != LVL_LOW);
		r10 = (spd_q != LVL_HIGH);
		single_rate = r100 ^ r10;
		// a floating speed strap leaves both rates open, so the warning stays off there
		warn_en = valid_q && warn_strap_q && single_rate;
		cu_run = warn_en && !pd_active && !i_copper_link_up;
		fo_run = warn_en && !pd_active && !i_fiber_link_up;
		both_down = warn_en && !i_copper_link_up && !i_fiber_link_up;
		cu_en_d = valid_q && !pd_active && cu_dis_n_s && !both_down && !cu_blank;
		fo_en_d = valid_q && !pd_active && fo_dis_n_s && !both_down && !fo_blank;
	end

	link_blank_timer #(
		.PERIOD(PERIOD_TICKS),
		.OFF(OFF_TICKS),
		.FAST_PERIOD(FAST_PERIOD_TICKS),
		.FAST_OFF(FAST_OFF_TICKS)
	) u_cu_blank (
		.i_mclk(i_mclk),
		.i_rst_n(i_rst_n),
		.i_tick(ref_tick),
		.i_run(cu_run),
		.i_fast(fast_q),
		.o_blank(cu_blank)
	);

	link_blank_timer #(
		.PERIOD(PERIOD_TICKS),
		.OFF(OFF_TICKS),
		.FAST_PERIOD(FAST_PERIOD_TICKS),
		.FAST_OFF(FAST_OFF_TICKS)
	) u_fo_blank (
		.i_mclk(i_mclk),
		.i_rst_n(i_rst_n),
		.i_tick(ref_tick),
		.i_run(fo_run),
		.i_fast(fast_q),
		.o_blank(fo_blank)
	);

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			cu_en_q <= 1'b0;
			fo_en_q <= 1'b0;
		end else begin
			cu_en_q <= cu_en_d;
			fo_en_q <= fo_en_d;
		end
	end

	assign o_mdio = out_q;
	assign o_mdio_oe = oe_q;
	assign o_phy_addr = addr_q;
	assign o_speed_code = spd_q;
	assign o_duplex_code = dpx_q;
	assign o_rate_100_en = r100;
	assign o_rate_10_en = r10;
	assign o_autoneg_en = r100 && r10;
	assign o_duplex_en = r100 && r10;
	assign o_transparent = (dpx_q == LVL_MID);
	assign o_warn_en = warn_en;
	assign o_test_fast = fast_q;
	assign o_config_valid = valid_q;
	assign o_power_down = pd_active;
	assign o_copper_tx_en = cu_en_q;
	assign o_fiber_tx_en = fo_en_q;

endmodule

// ===== test/link_far_side.sv
// reference clock source and the two network link partners facing the converter
`timescale 1ns/1ps
module link_far_side (
	input wire logic i_mclk,
	input wire logic i_cu_want,
	input wire logic i_fo_want,
	output logic o_refclk,
	output logic o_cu_up,
	output logic o_fo_up
);
	// free-running reference, phase offset so its edges never meet the main clock's
	initial begin
		o_refclk = 1'b0;
		#3;
		forever #20 o_refclk = ~o_refclk;
	end
	// link state comes from same-clock monitors, so it moves on the main clock edge
	always @(posedge i_mclk) begin
		o_cu_up <= i_cu_want;
		o_fo_up <= i_fo_want;
	end
endmodule

// ===== test/conv_cfg_chk.sv
// concurrent checks on the converter configuration and transmit control ports
`timescale 1ns/1ps
module conv_cfg_chk
	import conv_cfg_pkg::*;
#(
	parameter logic [STRAP_CNT_W-1:0] STRAP_TICKS = STRAP_CNT_W'(STRAP_DELAY_TICKS)
) (
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic i_power_down_n,
	input wire logic i_copper_tx_disable_n,
	input wire logic i_fiber_tx_disable_n,
	input wire logic [1:0] i_phy_addr_low_strap,
	input wire logic [1:0] i_phy_addr_mid_strap,
	input wire logic [1:0] i_phy_addr_high_warn_strap,
	input wire logic i_copper_link_up,
	input wire logic i_fiber_link_up,
	input wire logic o_mdio_oe,
	input wire logic [4:0] o_phy_addr,
	input wire logic [1:0] o_speed_code,
	input wire logic [1:0] o_duplex_code,
	input wire logic o_rate_100_en,
	input wire logic o_rate_10_en,
	input wire logic o_autoneg_en,
	input wire logic o_duplex_en,
	input wire logic o_transparent,
	input wire logic o_warn_en,
	input wire logic o_config_valid,
	input wire logic o_power_down,
	input wire logic o_copper_tx_en,
	input wire logic o_fiber_tx_en
);
	// window assumes a reference tick every 5 main cycles plus synchroniser slack
	localparam int LO = (int'(STRAP_TICKS) - 1) * 5;
	localparam int HI = int'(STRAP_TICKS) * 5 + 20;
	logic [15:0] wait_q;
	logic [15:0] wait_d;
	always_comb begin
		wait_d = wait_q;
		if (!i_power_down_n)
			wait_d = 16'h0000;
		else if (wait_q != 16'hFFFF)
			wait_d = wait_q + 16'h0001;
	end
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n)
			wait_q <= 16'h0000;
		else
			wait_q <= wait_d;
	end
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);
	////////////////////////////////////////////////////////////////////////////////
	sequence cu_drop;
		$fell(i_copper_link_up) && o_warn_en && i_fiber_link_up;
	endsequence
	sequence cu_dark;
		(!o_copper_tx_en || i_copper_link_up) [*8];
	endsequence
	strap_addr_a: assert property ($rose(o_config_valid) |->
		o_phy_addr == {i_phy_addr_high_warn_strap[0], i_phy_addr_mid_strap, i_phy_addr_low_strap})
		else $error("sampled address differs from straps");
	sample_delay_a: assert property ($rose(o_config_valid) |-> wait_q >= LO && wait_q <= HI)
		else $error("strap sampling outside its window");
	speed_high_a: assert property (o_config_valid && o_speed_code == LVL_HIGH |->
		o_rate_100_en && !o_rate_10_en && !o_autoneg_en && !o_duplex_en) else $error("high speed decode");
	speed_low_a: assert property (o_config_valid && o_speed_code == LVL_LOW |->
		!o_rate_100_en && o_rate_10_en && !o_autoneg_en && !o_duplex_en) else $error("low speed decode");
	speed_mid_a: assert property (o_config_valid && o_speed_code == LVL_MID |->
		o_rate_100_en && o_rate_10_en && o_transparent == (o_duplex_code == LVL_MID)) else $error("mid decode");
	warn_rate_a: assert property (o_warn_en |-> o_rate_100_en != o_rate_10_en)
		else $error("warning with two rates");
	code_hold_a: assert property (o_power_down && $past(o_power_down) |->
		$stable(o_phy_addr) && $stable(o_speed_code) && $stable(o_duplex_code)) else $error("codes moved");
	pd_quiet_a: assert property (o_power_down [*2] |-> !o_copper_tx_en && !o_fiber_tx_en)
		else $error("transmit while powered down");
	cu_disable_a: assert property (!i_copper_tx_disable_n [*7] |-> !o_copper_tx_en)
		else $error("copper transmit while disabled");
	fo_disable_a: assert property (!i_fiber_tx_disable_n [*7] |-> !o_fiber_tx_en)
		else $error("fiber transmit while disabled");
	both_down_a: assert property (o_warn_en && !i_copper_link_up && !i_fiber_link_up |=>
		!o_copper_tx_en && !o_fiber_tx_en) else $error("transmit with both links down");
	cu_blank_a: assert property (cu_drop |-> ##2 cu_dark)
		else $error("copper blanking missing");
	mdio_gate_a: assert property (o_mdio_oe |-> o_config_valid)
		else $error("data line driven before configuration");
endmodule
bind converter_config_and_link_control conv_cfg_chk #(.STRAP_TICKS(STRAP_TICKS)) u_chk (.i_mclk, .i_rst_n,
	.i_power_down_n, .i_copper_tx_disable_n, .i_fiber_tx_disable_n, .i_phy_addr_low_strap,
	.i_phy_addr_mid_strap, .i_phy_addr_high_warn_strap, .i_copper_link_up, .i_fiber_link_up, .o_mdio_oe,
	.o_phy_addr, .o_speed_code, .o_duplex_code, .o_rate_100_en, .o_rate_10_en, .o_autoneg_en, .o_duplex_en,
	.o_transparent, .o_warn_en, .o_config_valid, .o_power_down, .o_copper_tx_en, .o_fiber_tx_en);

// ===== test/tb.sv
// self-checking testbench for the converter configuration and link control block
`timescale 1ns/1ps
module tb
	import conv_cfg_pkg::*;
();
	localparam int ST = 20;
	localparam int PER = 40;
	localparam int OFF = 8;
	localparam int FPER = 20;
	localparam int FOFF = 4;
	logic i_mclk, i_rst_n, i_reference_clock_in, i_power_down_n, i_copper_tx_disable_n, i_fiber_tx_disable_n;
	logic i_speed_strap_hi, i_speed_strap_lo, i_duplex_strap_hi, i_duplex_strap_lo, i_copper_link_up;
	logic [1:0] i_phy_addr_low_strap, i_phy_addr_mid_strap, i_phy_addr_high_warn_strap;
	logic i_fiber_link_up, i_mdc, i_mdio, o_mdio, o_mdio_oe, o_rate_100_en, o_rate_10_en, o_autoneg_en;
	logic o_duplex_en, o_transparent, o_warn_en, o_test_fast, o_config_valid, o_power_down;
	logic o_copper_tx_en, o_fiber_tx_en, cu_want, fo_want, st_oe, st_d;
	logic [4:0] o_phy_addr;
	logic [4:0] cur_addr;
	logic [1:0] o_speed_code, o_duplex_code;
	int failures, tests_run;
	// pulled-up management line: released means high
	assign i_mdio = o_mdio_oe ? o_mdio : (st_oe ? st_d : 1'b1);
	converter_config_and_link_control #(.STRAP_TICKS(STRAP_CNT_W'(ST)), .PERIOD_TICKS(WARN_CNT_W'(PER)),
		.OFF_TICKS(WARN_CNT_W'(OFF)), .FAST_PERIOD_TICKS(WARN_CNT_W'(FPER)), .FAST_OFF_TICKS(WARN_CNT_W'(FOFF)))
		u_dut (.i_mclk, .i_rst_n, .i_reference_clock_in, .i_power_down_n, .i_copper_tx_disable_n,
		.i_fiber_tx_disable_n, .i_speed_strap_hi, .i_speed_strap_lo, .i_duplex_strap_hi, .i_duplex_strap_lo,
		.i_phy_addr_low_strap, .i_phy_addr_mid_strap, .i_phy_addr_high_warn_strap, .i_copper_link_up,
		.i_fiber_link_up, .i_mdc, .i_mdio, .o_mdio, .o_mdio_oe, .o_phy_addr, .o_speed_code, .o_duplex_code,
		.o_rate_100_en, .o_rate_10_en, .o_autoneg_en, .o_duplex_en, .o_transparent, .o_warn_en, .o_test_fast,
		.o_config_valid, .o_power_down, .o_copper_tx_en, .o_fiber_tx_en);
	link_far_side u_far (.i_mclk(i_mclk), .i_cu_want(cu_want), .i_fo_want(fo_want),
		.o_refclk(i_reference_clock_in), .o_cu_up(i_copper_link_up), .o_fo_up(i_fiber_link_up));
	initial begin
		i_mclk = 1'b0;
		forever #4 i_mclk = ~i_mclk;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic cyc(input int n);
		repeat (n) @(posedge i_mclk);
		#1;
	endtask
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic set_lvl(input level_t s, input level_t d);
		i_speed_strap_hi = (s == LVL_HIGH);
		i_speed_strap_lo = (s == LVL_LOW);
		i_duplex_strap_hi = (d == LVL_HIGH);
		i_duplex_strap_lo = (d == LVL_LOW);
	endtask
	// one station bit at 12.5 MHz: data set while the clock is low
	task automatic mbit(input logic b);
		i_mdc = 1'b0;
		st_oe = 1'b1;
		st_d = b;
		cyc(5);
		i_mdc = 1'b1;
		cyc(5);
	endtask
	task automatic mframe(input logic [1:0] op, input logic [15:0] wd, output logic [15:0] rd);
		logic [45:0] hdr;
		hdr = {32'hFFFFFFFF, 2'h1, op, cur_addr, MGMT_REG_TEST};
		rd = 16'h0000;
		for (int i = 45; i >= 0; i--)
			mbit(hdr[i]);
		if (op == MGMT_OP_WRITE) begin
			mbit(1'b1);
			mbit(1'b0);
			for (int i = 15; i >= 0; i--)
				mbit(wd[i]);
		end else begin
			st_oe = 1'b0;
			for (int i = 0; i < 18; i++) begin
				i_mdc = 1'b0;
				cyc(5);
				if (i == 1)
					chk("turnaround", 16'h0002, {o_mdio_oe, i_mdio});
				if (i >= 2)
					rd = {rd[14:0], i_mdio};
				i_mdc = 1'b1;
				cyc(5);
			end
			cyc(5);
			chk("line released", 1'b0, o_mdio_oe);
		end
		i_mdc = 1'b0;
		st_oe = 1'b0;
	endtask
	task automatic pd_cycle(input logic [4:0] old_a, input logic [4:0] new_a);
		i_power_down_n = 1'b0;
		cyc(10);
		chk("pd flag", 1'b1, o_power_down);
		chk("pd tx", 2'h0, {o_copper_tx_en, o_fiber_tx_en});
		i_power_down_n = 1'b1;
		cyc(ST * 3 - 5);
		chk("early addr", old_a, o_phy_addr);
		cyc(ST * 5 + 5);
		chk("late addr", new_a, o_phy_addr);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic boot();
		int n;
		n = 0;
		while (o_config_valid !== 1'b1 && n < 300) begin
			cyc(1);
			n++;
		end
		if (n >= 300) begin
			failures++;
			complete_run();
		end
		chk("boot delay", 1'b1, n >= ST * 3 && n <= ST * 8);
		chk("boot addr", 5'h19, o_phy_addr);
		chk("boot rates", 4'h8, {o_rate_100_en, o_rate_10_en, o_autoneg_en, o_duplex_en});
		chk("boot warn", 1'b1, o_warn_en);
		cyc(2);
		chk("boot tx", 2'h3, {o_copper_tx_en, o_fiber_tx_en});
	endtask
	task automatic disables();
		// held past the checker's seven-cycle window so its disable checks really fire
		i_copper_tx_disable_n = 1'b0;
		cyc(8);
		chk("copper off", 2'h1, {o_copper_tx_en, o_fiber_tx_en});
		i_copper_tx_disable_n = 1'b1;
		i_fiber_tx_disable_n = 1'b0;
		cyc(8);
		chk("fiber off", 2'h2, {o_copper_tx_en, o_fiber_tx_en});
		i_fiber_tx_disable_n = 1'b1;
		cyc(6);
	endtask
	task automatic modes();
		level_t s;
		level_t d;
		logic [4:0] a;
		for (int i = 0; i < 6; i++) begin
			s = level_t'(i / 2);
			d = (i % 2) ? LVL_MID : ((i == 2) ? LVL_HIGH : LVL_LOW);
			a = {1'b0, 2'(i + 1), 2'(i)};
			set_lvl(s, d);
			i_phy_addr_low_strap = 2'(i);
			i_phy_addr_mid_strap = 2'(i + 1);
			i_phy_addr_high_warn_strap = 2'h2;
			pd_cycle(cur_addr, a);
			cur_addr = a;
			chk("speed code", s, o_speed_code);
			chk("duplex code", d, o_duplex_code);
			chk("rates", {s != LVL_LOW, s != LVL_HIGH}, {o_rate_100_en, o_rate_10_en});
			if (s != LVL_MID)
				chk("no negotiation", 2'h0, {o_autoneg_en, o_duplex_en});
			else
				chk("transparent", d == LVL_MID, o_transparent);
			chk("warn", s != LVL_MID, o_warn_en);
		end
	endtask
	// copper link drops with fiber up: measure one dark span and the lit span after it
	task automatic blank_run(input int off, input int per);
		int n0;
		int n1;
		n0 = 0;
		n1 = 0;
		cu_want = 1'b0;
		cyc(3);
		chk("blank start", 1'b0, o_copper_tx_en);
		while (o_copper_tx_en === 1'b0 && n0 < 1000) begin
			cyc(1);
			n0++;
		end
		while (o_copper_tx_en === 1'b1 && n1 < 1000) begin
			cyc(1);
			n1++;
		end
		if (n0 >= 1000 || n1 >= 1000) begin
			failures++;
			complete_run();
		end
		// the first dark span loses up to one reference period to the tick phase at link loss
		chk("dark span", 1'b1, n0 >= off * 5 - 5 && n0 <= off * 5 - 1);
		chk("lit span", 1'b1, n1 >= (per - off) * 5 - 3 && n1 <= (per - off) * 5 + 3);
		chk("fiber lit", 1'b1, o_fiber_tx_en);
		cu_want = 1'b1;
		cyc(3);
		chk("relink", 1'b1, o_copper_tx_en);
	endtask
	task automatic both_down();
		cu_want = 1'b0;
		fo_want = 1'b0;
		cyc(OFF * 5 + 20);
		chk("both dark", 2'h0, {o_copper_tx_en, o_fiber_tx_en});
		cu_want = 1'b1;
		fo_want = 1'b1;
		cyc(3);
		chk("both lit", 2'h3, {o_copper_tx_en, o_fiber_tx_en});
	endtask
	task automatic mgmt();
		logic [15:0] rd;
		mframe(MGMT_OP_WRITE, 16'h0001, rd);
		cyc(10);
		chk("fast bit", 1'b1, o_test_fast);
		mframe(MGMT_OP_READ, 16'h0000, rd);
		chk("read back", 16'h0001, rd);
		// a frame to another station address must leave the register alone
		cur_addr = cur_addr ^ 5'h01;
		mframe(MGMT_OP_WRITE, 16'h0000, rd);
		cur_addr = cur_addr ^ 5'h01;
		cyc(10);
		chk("foreign write", 1'b1, o_test_fast);
		blank_run(FOFF, FPER);
		pd_cycle(cur_addr, cur_addr);
		chk("fast cleared", 1'b0, o_test_fast);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		failures = 0;
		tests_run = 0;
		cur_addr = 5'h19;
		i_rst_n = 1'b0;
		i_power_down_n = 1'b1;
		i_copper_tx_disable_n = 1'b1;
		i_fiber_tx_disable_n = 1'b1;
		set_lvl(LVL_HIGH, LVL_LOW);
		i_phy_addr_low_strap = 2'h1;
		i_phy_addr_mid_strap = 2'h2;
		i_phy_addr_high_warn_strap = 2'h3;
		cu_want = 1'b1;
		fo_want = 1'b1;
		i_mdc = 1'b0;
		st_oe = 1'b0;
		st_d = 1'b1;
		cyc(8);
		i_rst_n = 1'b1;
		boot();
		disables();
		modes();
		blank_run(OFF, PER);
		both_down();
		mgmt();
		complete_run();
	end
endmodule
